// >>> sffe_consts.svh
// Opcodes, counts and field positions for the serial flash front end.
`ifndef SFFE_CONSTS_SVH
`define SFFE_CONSTS_SVH
`define SFFE_BYTE_MSB 3'h7
`define SFFE_PAGE_MAX_BYTES 9'h100
`define SFFE_ADDR_BYTES 2'h3
`define SFFE_CMD_READ 8'h03
`define SFFE_CMD_DUAL_READ 8'h3B
`define SFFE_CMD_PROGRAM 8'h02
`define SFFE_CMD_ERASE_PAGE 8'h81
`define SFFE_CMD_ERASE_4K 8'h20
`define SFFE_CMD_ERASE_32K 8'h52
`define SFFE_CMD_ERASE_CHIP 8'h60
`define SFFE_CMD_STATUS 8'h05
`define SFFE_STAT_BUSY 0
`define SFFE_STAT_FAIL 5
`endif

// >>> sffe_pkg.sv
// Types shared by the serial flash front end files.
package sffe_pkg;
    typedef enum logic [1:0] {
        SFFE_ER_PAGE,
        SFFE_ER_4K,
        SFFE_ER_32K,
        SFFE_ER_CHIP
    } sffe_erase_t;
    typedef enum logic [2:0] {
        SFFE_ST_CMD,
        SFFE_ST_ADDR,
        SFFE_ST_DUMMY,
        SFFE_ST_DATA_IN,
        SFFE_ST_DATA_OUT,
        SFFE_ST_IGNORE
    } sffe_phase_t;
endpackage

// >>> sffe_sync.sv
// Two flip-flop synchroniser bank for the link pins.
`timescale 1ns/1ps
`default_nettype none
module sffe_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sffe_sync_state_t;
    sffe_sync_state_t st;
    sffe_sync_state_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    // Registers both stages; pins idle high after reset.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;
endmodule // sffe_sync
`default_nettype wire

// >>> sffe_front_end.sv
// Serial flash link front end: framing, shifting and dual read lanes.
`timescale 1ns/1ps
`default_nettype none
`include "sffe_consts.svh"
module sffe_front_end
    import sffe_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Link pins from the host.
    input wire logic sel_b_in,
    input wire logic sclk_in,
    input wire logic pause_b_in,
    input wire logic dual_lane_low_in,
    // Link pins toward the host; enables are low while driving.
    output logic dual_lane_low_out,
    output logic dual_lane_low_oe_b_out,
    output logic dual_lane_high_out,
    output logic dual_lane_high_oe_b_out,
    // Array core side.
    input wire logic [7:0] rd_data_in,
    input wire logic core_busy_in,
    input wire logic core_fail_in,
    output logic [23:0] addr_out,
    output logic rd_req_out,
    output logic [7:0] wr_data_out,
    output logic wr_valid_out,
    output logic prog_start_out,
    output logic erase_start_out,
    output logic [1:0] erase_kind_out,
    output logic standby_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sclk_q;
        logic sel_q;
        sffe_phase_t phase;
        logic [7:0] cmd;
        logic [7:0] shift_in;
        logic [2:0] bit_cnt;
        logic [1:0] addr_cnt;
        logic [23:0] addr;
        logic [8:0] byte_cnt;
        logic [7:0] shift_out;
        logic out_lo;
        logic out_hi;
        logic float_lo; // Low lane enable, low while driving.
        logic float_hi; // High lane enable, low while driving.
        logic rd_req;
        logic [7:0] wr_data;
        logic wr_valid;
        logic prog_start;
        logic erase_start;
        logic [1:0] erase_kind;
        logic fail_seen;
        logic standby;
    } sffe_state_t;
    sffe_state_t st;
    sffe_state_t next_st;
    logic [3:0] pins;

    // Every pin from the host passes two flip-flops first.
    sffe_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in({sel_b_in, sclk_in, pause_b_in, dual_lane_low_in}),
        .sync_out(pins)
    );

    // Maps an erase opcode onto its size class.
    function automatic logic [1:0] erase_kind_of(input logic [7:0] c);
        unique case (c)
            `SFFE_CMD_ERASE_PAGE: erase_kind_of = 2'(SFFE_ER_PAGE);
            `SFFE_CMD_ERASE_4K: erase_kind_of = 2'(SFFE_ER_4K);
            `SFFE_CMD_ERASE_32K: erase_kind_of = 2'(SFFE_ER_32K);
            default: erase_kind_of = 2'(SFFE_ER_CHIP);
        endcase
    endfunction

    // Tells whether an opcode is one of the four erase commands.
    function automatic logic is_erase(input logic [7:0] c);
        is_erase = (c == `SFFE_CMD_ERASE_PAGE) || (c == `SFFE_CMD_ERASE_4K)
            || (c == `SFFE_CMD_ERASE_32K) || (c == `SFFE_CMD_ERASE_CHIP);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic sel_b;
    logic sclk;
    logic held;
    logic rise;
    logic fall;
    logic [7:0] in_byte;
    logic [7:0] status;
    assign sel_b = pins[3];
    assign sclk = pins[2];
    assign held = !pins[1];
    // Edges are found on the synchronised clock, so either idle level works.
    assign rise = sclk && !st.sclk_q && !held;
    assign fall = !sclk && st.sclk_q && !held;
    assign in_byte = {st.shift_in[6:0], pins[0]};
    assign status = {2'h0, st.fail_seen, 4'h0, core_busy_in};

    always_comb begin
        next_st = st;
        next_st.sclk_q = sclk;
        next_st.sel_q = sel_b;
        next_st.rd_req = 1'b0;
        next_st.wr_valid = 1'b0;
        next_st.prog_start = 1'b0;
        next_st.erase_start = 1'b0;
        if (core_fail_in) begin
            next_st.fail_seen = 1'b1;
        end
        // Standby only once deselected and the core is idle.
        next_st.standby = sel_b && !core_busy_in;
        if (sel_b) begin
            // Deselected: lanes float, input bits are dropped.
            next_st.float_lo = 1'b1;
            next_st.float_hi = 1'b1;
            next_st.phase = SFFE_ST_IGNORE;
            if (!st.sel_q && st.phase == SFFE_ST_DATA_IN
                && st.byte_cnt != 9'h000) begin
                next_st.prog_start = 1'b1;
            end
            if (!st.sel_q && st.phase == SFFE_ST_IGNORE
                && is_erase(st.cmd) && st.bit_cnt == 3'h0) begin
                next_st.erase_start = 1'b1;
                next_st.erase_kind = erase_kind_of(st.cmd);
            end
        end else if (st.sel_q) begin
            // Falling select opens a new frame.
            next_st.phase = SFFE_ST_CMD;
            next_st.bit_cnt = 3'h0;
            next_st.addr_cnt = 2'h0;
            next_st.byte_cnt = 9'h000;
            next_st.float_lo = 1'b1;
            next_st.float_hi = 1'b1;
        end else if (held) begin
            next_st.float_lo = 1'b1;
            next_st.float_hi = 1'b1;
        end else if (rise && st.phase != SFFE_ST_DATA_OUT) begin
            // Input bits arrive most significant first.
            next_st.shift_in = in_byte;
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == `SFFE_BYTE_MSB) begin
                unique case (st.phase)
                    SFFE_ST_CMD: begin
                        next_st.cmd = in_byte;
                        if (in_byte == `SFFE_CMD_STATUS) begin
                            next_st.phase = SFFE_ST_DATA_OUT;
                            next_st.shift_out = status;
                            next_st.fail_seen = core_fail_in;
                        end else if (in_byte == `SFFE_CMD_ERASE_CHIP) begin
                            next_st.phase = SFFE_ST_IGNORE;
                        end else begin
                            next_st.phase = SFFE_ST_ADDR;
                        end
                    end
                    SFFE_ST_ADDR: begin
                        next_st.addr = {st.addr[15:0], in_byte};
                        next_st.addr_cnt = st.addr_cnt + 2'h1;
                        if (st.addr_cnt == `SFFE_ADDR_BYTES - 2'h1) begin
                            if (st.cmd == `SFFE_CMD_PROGRAM) begin
                                next_st.phase = SFFE_ST_DATA_IN;
                            end else if (st.cmd == `SFFE_CMD_DUAL_READ) begin
                                next_st.phase = SFFE_ST_DUMMY;
                                next_st.rd_req = 1'b1;
                            end else if (st.cmd == `SFFE_CMD_READ) begin
                                next_st.phase = SFFE_ST_DATA_OUT;
                                next_st.rd_req = 1'b1;
                            end else begin
                                next_st.phase = SFFE_ST_IGNORE;
                            end
                        end
                    end
                    SFFE_ST_DUMMY: begin
                        next_st.phase = SFFE_ST_DATA_OUT;
                    end
                    SFFE_ST_DATA_IN: begin
                        // Bytes past a full page are not taken.
                        if (st.byte_cnt != `SFFE_PAGE_MAX_BYTES) begin
                            next_st.wr_data = in_byte;
                            next_st.wr_valid = 1'b1;
                            next_st.byte_cnt = st.byte_cnt + 9'h001;
                        end
                    end
                    default: begin
                        next_st.phase = SFFE_ST_IGNORE;
                    end
                endcase
            end
        end else if (fall && st.phase == SFFE_ST_DATA_OUT) begin
            // Output changes after the falling edge, high bit first.
            if (st.cmd == `SFFE_CMD_DUAL_READ) begin
                next_st.out_hi = st.shift_out[7];
                next_st.out_lo = st.shift_out[6];
                next_st.float_hi = 1'b0;
                next_st.float_lo = 1'b0;
                next_st.shift_out = {st.shift_out[5:0], 2'h0};
                next_st.bit_cnt = st.bit_cnt + 3'h2;
                if (st.bit_cnt == 3'h6) begin
                    // The next byte is fetched now and loaded below.
                    next_st.addr = st.addr + 24'h000001;
                    next_st.rd_req = 1'b1;
                end
            end else begin
                next_st.out_hi = st.shift_out[7];
                next_st.float_hi = 1'b0;
                next_st.shift_out = {st.shift_out[6:0], 1'b0};
                next_st.bit_cnt = st.bit_cnt + 3'h1;
                if (st.bit_cnt == `SFFE_BYTE_MSB) begin
                    if (st.cmd == `SFFE_CMD_STATUS) begin
                        next_st.shift_out = status;
                    end else begin
                        next_st.addr = st.addr + 24'h000001;
                        next_st.rd_req = 1'b1;
                    end
                end
            end
        end
        // Each fetched byte is loaded one cycle after its request.
        if (st.rd_req) begin
            next_st.shift_out = rd_data_in;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.sel_q <= 1'b1;
            st.phase <= SFFE_ST_IGNORE;
            st.standby <= 1'b1;
            st.float_lo <= 1'b1;
            st.float_hi <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from state flip-flops.
    assign dual_lane_low_out = st.out_lo;
    assign dual_lane_low_oe_b_out = st.float_lo;
    assign dual_lane_high_out = st.out_hi;
    assign dual_lane_high_oe_b_out = st.float_hi;
    assign addr_out = st.addr;
    assign rd_req_out = st.rd_req;
    assign wr_data_out = st.wr_data;
    assign wr_valid_out = st.wr_valid;
    assign prog_start_out = st.prog_start;
    assign erase_start_out = st.erase_start;
    assign erase_kind_out = st.erase_kind;
    assign standby_out = st.standby;
endmodule // sffe_front_end
`default_nettype wire

// >>> sffe_front_end_sva.sv
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module sffe_front_end_sva (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Link pins.
    input wire logic sel_b_in,
    input wire logic sclk_in,
    input wire logic pause_b_in,
    input wire logic dual_lane_low_oe_b_out,
    input wire logic dual_lane_high_out,
    input wire logic dual_lane_high_oe_b_out,
    // Core side.
    input wire logic core_busy_in,
    input wire logic prog_start_out,
    input wire logic erase_start_out,
    input wire logic standby_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_float_when_off: assert property (sel_b_in [*6] |-> dual_lane_high_oe_b_out)
        else $error("Output lane driven while deselected.");
    a_pause_floats: assert property (!pause_b_in [*6] |-> dual_lane_high_oe_b_out)
        else $error("Output lane driven while paused.");
    a_standby_waits: assert property (core_busy_in [*3] |-> !standby_out)
        else $error("Standby entered while core busy.");
    a_no_standby_sel: assert property (!sel_b_in [*6] |-> !standby_out)
        else $error("Standby while selected.");
    a_prog_at_end: assert property (prog_start_out |-> sel_b_in ##1 !prog_start_out)
        else $error("Program start not a pulse after deselect.");
    a_erase_at_end: assert property (erase_start_out |-> sel_b_in ##1 !erase_start_out)
        else $error("Erase start not a pulse after deselect.");
    a_lane_on_fall: assert property (!dual_lane_high_oe_b_out && !$past(dual_lane_high_oe_b_out)
        && $changed(dual_lane_high_out) |-> !sclk_in)
        else $error("Output lane changed while clock high.");
    a_dual_both: assert property (!dual_lane_low_oe_b_out |-> !dual_lane_high_oe_b_out)
        else $error("Low lane driven alone.");
endmodule // sffe_front_end_sva
bind sffe_front_end sffe_front_end_sva sffe_front_end_sva_i (.*);
`default_nettype wire

// >>> sffe_host.sv
// Host controller model that drives the link pins of the front end.
`timescale 1ns/1ps
`default_nettype none
module sffe_host (
    // Clock and lane levels on the wires.
    input wire logic clk_in,
    input wire logic hi_wire_in,
    input wire logic lo_wire_in,
    // Link pins toward the device.
    output logic sel_b_out,
    output logic sclk_out,
    output logic pause_b_out,
    output logic lane_out
);
    logic cpol;
    // Idle levels: deselected, clock low, no pause.
    initial begin
        cpol = 1'h0;
        sel_b_out = 1'h1;
        sclk_out = 1'h0;
        pause_b_out = 1'h1;
        lane_out = 1'h0;
    end
    // Half a link clock period: six system clocks, 24 ns.
    task automatic half();
        repeat (6) @(negedge clk_in);
    endtask
    // Opens a frame from the chosen idle clock level.
    task automatic open_frame(input logic mode3);
        cpol = mode3;
        sclk_out = mode3;
        half();
        sel_b_out = 1'h0;
        half();
    endtask
    // Parks the clock at idle and ends the frame.
    task automatic close_frame();
        sclk_out = cpol;
        half();
        sel_b_out = 1'h1;
        lane_out = ~lane_out;
        half();
    endtask
    // Sends one byte on the input lane and gathers the output lane.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'h0;
            lane_out = tx[i];
            half();
            sclk_out = 1'h1;
            rx[i] = hi_wire_in;
            half();
        end
    endtask
    // Gathers one byte over both lanes, two bits per clock.
    task automatic xfer2(output logic [7:0] rx);
        for (int i = 7; i > 0; i -= 2) begin
            sclk_out = 1'h0;
            half();
            sclk_out = 1'h1;
            rx[i] = hi_wire_in;
            rx[i-1] = lo_wire_in;
            half();
        end
    endtask
    // Pauses with the clock low and wiggles clock and lane meanwhile.
    task automatic pause(input int n);
        sclk_out = 1'h0;
        half();
        pause_b_out = 1'h0;
        repeat (2 * n) begin
            @(negedge clk_in);
            sclk_out = ~sclk_out;
            lane_out = ~lane_out;
        end
        half();
        pause_b_out = 1'h1;
        half();
    endtask
endmodule // sffe_host
`default_nettype wire

// >>> tb_sffe_front_end.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
`include "sffe_consts.svh"
module tb_sffe_front_end;
    logic clk_in = 1'h0, rst_b_in = 1'h0, core_busy_in = 1'h0;
    logic core_fail_in = 1'h0, host_lane, hi_wire;
    logic sel_b_in, sclk_in, pause_b_in, dual_lane_low_in;
    logic dual_lane_low_out, dual_lane_low_oe_b_out, dual_lane_high_out;
    logic dual_lane_high_oe_b_out, rd_req_out, wr_valid_out, prog_start_out;
    logic erase_start_out, standby_out;
    logic [7:0] rd_data_in = 8'h00, wr_data_out;
    logic [23:0] addr_out;
    logic [1:0] erase_kind_out, kind_seen;
    logic [7:0] wr_q[$], exp_q[$];
    logic [7:0] ercmd[4] = '{`SFFE_CMD_ERASE_PAGE, `SFFE_CMD_ERASE_4K,
        `SFFE_CMD_ERASE_32K, `SFFE_CMD_ERASE_CHIP};
    int bad_count = 0, n_compared = 0, n_prog = 0, n_erase = 0, cycles = 0;
    int seed = 57, n_fetch = 0;
    // Wire levels: a released high lane shows the inverse of its last value; a released low lane shows the host lane.
    assign dual_lane_low_in = dual_lane_low_oe_b_out ? host_lane : dual_lane_low_out;
    assign hi_wire = dual_lane_high_oe_b_out ? ~dual_lane_high_out : dual_lane_high_out;
    sffe_front_end sffe_front_end_i (.*);
    sffe_host sffe_host_i (.clk_in(clk_in), .hi_wire_in(hi_wire),
        .lo_wire_in(dual_lane_low_in), .sel_b_out(sel_b_in),
        .sclk_out(sclk_in), .pause_b_out(pause_b_in), .lane_out(host_lane));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // Array model answers a byte derived from the address.
    always @(negedge clk_in) begin
        rd_data_in <= addr_out[7:0] ^ 8'h5A;
    end
    // Records core requests and cuts a hang short.
    always @(posedge clk_in) begin
        if (wr_valid_out === 1'h1) wr_q.push_back(wr_data_out);
        if (prog_start_out === 1'h1) n_prog++;
        if (erase_start_out === 1'h1) n_erase++;
        if (erase_start_out === 1'h1) kind_seen = erase_kind_out;
        if (rd_req_out === 1'h1) n_fetch++;
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send_addr(input logic [23:0] a);
        logic [7:0] rx;
        for (int k = 16; k >= 0; k -= 8) sffe_host_i.xfer(a[k+:8], rx);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence: programs, erases, reads, status and standby.
    initial begin
        logic [7:0] rx;
        logic [23:0] a;
        int n;
        repeat (3) @(negedge clk_in);
        rst_b_in = 1'h1;
        repeat (3) @(negedge clk_in);
        for (int m = 0; m < 2; m++) begin
            n = m ? 257 : 1;
            sffe_host_i.open_frame(m[0]);
            sffe_host_i.xfer(`SFFE_CMD_PROGRAM, rx);
            send_addr(24'($random(seed)));
            for (int k = 0; k < n; k++) begin
                exp_q.push_back(8'($random(seed)));
                sffe_host_i.xfer(exp_q[k], rx);
                if (k == 0) sffe_host_i.pause(10);
            end
            sffe_host_i.close_frame();
            check("bytes", 32'(n > 256 ? 256 : n), 32'(wr_q.size()));
            foreach (wr_q[k]) check("byte", 32'(exp_q[k]), 32'(wr_q[k]));
            check("programs", 32'(m + 1), 32'(n_prog));
            wr_q.delete();
            exp_q.delete();
            sffe_host_i.xfer(8'($random(seed)), rx);
        end
        check("idle bytes", 32'h0, 32'(wr_q.size()));
        for (int e = 0; e < 4; e++) begin
            sffe_host_i.open_frame(1'h0);
            sffe_host_i.xfer(ercmd[e], rx);
            if (e < 3) send_addr(24'($random(seed)));
            sffe_host_i.close_frame();
            check("erases", 32'(e + 1), 32'(n_erase));
            check("kind", 32'(e), 32'(kind_seen));
        end
        for (int d = 0; d < 2; d++) begin
            a = 24'($random(seed));
            sffe_host_i.open_frame(d[0]);
            sffe_host_i.xfer(d ? `SFFE_CMD_DUAL_READ : `SFFE_CMD_READ, rx);
            send_addr(a);
            if (d) sffe_host_i.xfer(8'h00, rx);
            if (d) sffe_host_i.xfer2(rx);
            else sffe_host_i.xfer(8'h00, rx);
            check("read", 32'(a[7:0] ^ 8'h5A), 32'(rx));
            check("next addr", 32'(a + 24'h1), 32'(addr_out));
            check("fetches", 32'(2 * d + 2), 32'(n_fetch));
            sffe_host_i.pause(4);
            sffe_host_i.close_frame();
        end
        core_fail_in = 1'h1;
        @(negedge clk_in);
        core_fail_in = 1'h0;
        core_busy_in = 1'h1;
        sffe_host_i.open_frame(1'h0);
        sffe_host_i.xfer(`SFFE_CMD_STATUS, rx);
        sffe_host_i.xfer(8'h00, rx);
        check("status", 32'h3, 32'({rx[`SFFE_STAT_FAIL], rx[`SFFE_STAT_BUSY]}));
        sffe_host_i.close_frame();
        check("standby busy", 32'h0, 32'(standby_out));
        core_busy_in = 1'h0;
        repeat (4) @(negedge clk_in);
        check("standby idle", 32'h1, 32'(standby_out));
        check("lane float", 32'h1, 32'(dual_lane_high_oe_b_out));
        wrap_up();
    end
endmodule // tb_sffe_front_end
`default_nettype wire
